// ### hw/boot_lock_fuse_access.sv
// Self-programming sequencer: boot lock setting, flash write timing, lock and fuse read-back
`timescale 1ns/1ps
`default_nettype none

module boot_lock_fuse_access #(
    parameter int PROG_CYCLES = boot_lock_pkg::PROG_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    input  wire logic        SPM_EXEC,
    input  wire logic        LPM_EXEC,
    input  wire logic [15:0] Z_POINTER,
    input  wire logic [7:0]  GENERAL_REGISTER_ZERO,
    input  wire logic [7:0]  FLASH_READ_BYTE,
    input  wire logic        EEPROM_WRITE_BUSY,
    input  wire logic [5:0]  LOCK_BITS_NV,
    input  wire logic [7:0]  FUSE_LOW_BYTE,
    input  wire logic [7:0]  FUSE_HIGH_BYTE,
    input  wire logic [7:0]  FUSE_EXTENDED_BYTE,
    output logic [7:0]       LPM_DATA,
    output logic             LPM_VALID,
    output logic             FLASH_ERASE_GO,
    output logic             PAGE_WRITE_CMD,
    output logic             FLASH_PROG_BUSY,
    output logic             SECTION_READ_BLOCK,
    output logic [5:0]       LOCK_PROG_MASK,
    output logic             LOCK_PROG_STROBE
);

    typedef struct packed {
        boot_lock_pkg::seq_state_t seq;
        boot_lock_pkg::op_t        op;
        logic [4:0]                cmd;
        logic                      busy_flag;
        logic [2:0]                win;
        logic                      wr_pend;
        logic [7:0]                wr_addr;
        logic                      rd_ok;
        logic [31:0]               rdata;
        logic [7:0]                lpm_data;
        logic                      lpm_valid;
        logic                      erase_go;
        logic                      pgwr_go;
        logic                      prog_busy;
        logic                      read_block;
        logic [5:0]                lock_mask;
        logic                      lock_strobe;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;
    logic        timer_start;
    logic        timer_busy;
    logic        timer_done;

    // ********************************************************************
    // Command decode, used by store-program handling; load-program handling checks the command code
    // ********************************************************************
    function automatic boot_lock_pkg::op_t decode_cmd(input logic [4:0] cmd);
        case (cmd)
            boot_lock_pkg::CMD_LOCK_SET: decode_cmd = boot_lock_pkg::OP_LOCK_SET;
            boot_lock_pkg::CMD_ERASE:    decode_cmd = boot_lock_pkg::OP_ERASE;
            boot_lock_pkg::CMD_PAGE_WR:  decode_cmd = boot_lock_pkg::OP_PAGE_WR;
            boot_lock_pkg::CMD_REENABLE: decode_cmd = boot_lock_pkg::OP_REENABLE;
            default:                     decode_cmd = boot_lock_pkg::OP_NONE;
        endcase
    endfunction : decode_cmd

    // ********************************************************************
    // Flash write timer
    // ********************************************************************
    prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_prog_timer (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .start (timer_start),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    assign timer_start = (state_reg.seq == boot_lock_pkg::ST_ARMED) && SPM_EXEC && !EEPROM_WRITE_BUSY
                         && (state_reg.op == boot_lock_pkg::OP_LOCK_SET || state_reg.op == boot_lock_pkg::OP_ERASE
                             || state_reg.op == boot_lock_pkg::OP_PAGE_WR);

    // ********************************************************************
    // Sequencer and bus slave
    // ********************************************************************
    always_comb begin
        logic        take;
        logic [7:0]  wbyte;
        logic [7:0]  lock_byte;
        take      = 1'b0;
        wbyte     = 8'h00;
        lock_byte = 8'h00;

        state_next             = state_reg;
        state_next.lpm_valid   = 1'b0;
        state_next.erase_go    = 1'b0;
        state_next.pgwr_go     = 1'b0;
        state_next.lock_strobe = 1'b0;
        state_next.prog_busy   = timer_busy;

        // Bus address phase; zero wait states, read data ready in the data phase
        take = HSEL && HREADY && HTRANS[1];
        state_next.wr_pend = take && HWRITE;
        state_next.rd_ok   = take && !HWRITE;
        if (take) begin
            state_next.wr_addr = HADDR[7:0];
        end
        state_next.rdata = 32'h0000_0000;
        if (take && !HWRITE) begin
            if (HADDR[7:0] == boot_lock_pkg::CTRL_OFFSET) begin
                state_next.rdata[4:0]                        = state_reg.cmd;
                state_next.rdata[boot_lock_pkg::BUSYFLAG_BIT] = state_reg.busy_flag;
            end else if (HADDR[7:0] == boot_lock_pkg::STATUS_OFFSET) begin
                state_next.rdata[1:0] = {EEPROM_WRITE_BUSY, timer_busy};
            end
        end

        // Lock byte image, unused high bits read as unprogrammed
        lock_byte = {boot_lock_pkg::LOCK_UNUSED_HI, LOCK_BITS_NV};

        case (state_reg.seq)
            boot_lock_pkg::ST_IDLE: begin
                // Control writes ignored while an EEPROM write runs or a command is pending
                if (state_reg.wr_pend && state_reg.wr_addr == boot_lock_pkg::CTRL_OFFSET
                    && !EEPROM_WRITE_BUSY) begin
                    wbyte = HWDATA[7:0];
                    if (wbyte[boot_lock_pkg::EN_BIT]) begin
                        state_next.cmd = wbyte[4:0] & boot_lock_pkg::CMD_MASK;
                        state_next.win = boot_lock_pkg::SPM_WINDOW;
                        state_next.seq = boot_lock_pkg::ST_ARMED;
                        state_next.op  = decode_cmd(wbyte[4:0]);
                    end
                end
                if (LPM_EXEC) begin
                    state_next.lpm_data  = FLASH_READ_BYTE;
                    state_next.lpm_valid = 1'b1;
                end
            end
            boot_lock_pkg::ST_ARMED: begin
                state_next.win = state_reg.win - 3'h1;
                if (SPM_EXEC && !EEPROM_WRITE_BUSY && state_reg.op != boot_lock_pkg::OP_NONE) begin
                    case (state_reg.op)
                        boot_lock_pkg::OP_LOCK_SET: begin
                            // Z-pointer is not looked at for this command
                            state_next.lock_mask = {GENERAL_REGISTER_ZERO[boot_lock_pkg::LOCK_BOOT_MSB:
                                                    boot_lock_pkg::LOCK_BOOT_LSB], 2'h3};
                            state_next.seq = boot_lock_pkg::ST_PROG;
                        end
                        boot_lock_pkg::OP_ERASE: begin
                            state_next.erase_go   = 1'b1;
                            state_next.busy_flag  = 1'b1;
                            state_next.read_block = 1'b1;
                            state_next.seq        = boot_lock_pkg::ST_PROG;
                        end
                        boot_lock_pkg::OP_PAGE_WR: begin
                            state_next.pgwr_go    = 1'b1;
                            state_next.busy_flag  = 1'b1;
                            state_next.read_block = 1'b1;
                            state_next.seq        = boot_lock_pkg::ST_PROG;
                        end
                        boot_lock_pkg::OP_REENABLE: begin
                            state_next.busy_flag = 1'b0;
                            state_next.cmd       = 5'h00;
                            state_next.seq       = boot_lock_pkg::ST_IDLE;
                        end
                        default: begin
                            state_next.seq = boot_lock_pkg::ST_ARMED;
                        end
                    endcase
                end else if (LPM_EXEC) begin
                    state_next.lpm_data  = FLASH_READ_BYTE;
                    state_next.lpm_valid = 1'b1;
                    // Armed read only inside the shorter load window
                    if (state_reg.cmd == boot_lock_pkg::CMD_LOCK_SET
                        && state_reg.win > (boot_lock_pkg::SPM_WINDOW - boot_lock_pkg::LPM_WINDOW)
                        && !EEPROM_WRITE_BUSY) begin
                        case (Z_POINTER)
                            boot_lock_pkg::Z_LOCK:      state_next.lpm_data = lock_byte;
                            boot_lock_pkg::Z_FUSE_LOW:  state_next.lpm_data = FUSE_LOW_BYTE;
                            boot_lock_pkg::Z_FUSE_HIGH: state_next.lpm_data = FUSE_HIGH_BYTE;
                            boot_lock_pkg::Z_FUSE_EXT:  state_next.lpm_data = FUSE_EXTENDED_BYTE;
                            default:                    state_next.lpm_data = FLASH_READ_BYTE;
                        endcase
                        state_next.cmd = 5'h00;
                        state_next.op  = boot_lock_pkg::OP_NONE;
                        state_next.seq = boot_lock_pkg::ST_IDLE;
                    end
                end
                // Window closed with nothing done: drop the command untouched
                if (state_reg.win == 3'h1 && state_next.seq == boot_lock_pkg::ST_ARMED) begin
                    state_next.cmd = 5'h00;
                    state_next.op  = boot_lock_pkg::OP_NONE;
                    state_next.seq = boot_lock_pkg::ST_IDLE;
                end
            end
            boot_lock_pkg::ST_PROG: begin
                // Fetch never stalls for lock writes; only page ops block the section
                if (LPM_EXEC) begin
                    state_next.lpm_data  = FLASH_READ_BYTE;
                    state_next.lpm_valid = 1'b1;
                end
                if (timer_done) begin
                    state_next.lock_strobe = (state_reg.op == boot_lock_pkg::OP_LOCK_SET);
                    state_next.read_block  = 1'b0;
                    state_next.cmd         = 5'h00;
                    state_next.op          = boot_lock_pkg::OP_NONE;
                    state_next.seq         = boot_lock_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next.seq = boot_lock_pkg::ST_IDLE;
            end
        endcase

        if (!RST_B) begin
            state_next = '0;
            state_next.seq       = boot_lock_pkg::ST_IDLE;
            state_next.op        = boot_lock_pkg::OP_NONE;
            state_next.prog_busy = timer_busy;
            state_next.lock_mask = boot_lock_pkg::LOCK_MASK_NONE;
            // A running write keeps its target and commits at the end if reset is released before the timer finishes
            if (timer_busy) begin
                state_next.op         = state_reg.op;
                state_next.lock_mask  = state_reg.lock_mask;
                state_next.busy_flag  = state_reg.busy_flag;
                state_next.read_block = state_reg.read_block;
            end
        end else if (timer_done && state_reg.seq != boot_lock_pkg::ST_PROG) begin
            state_next.lock_strobe = (state_reg.op == boot_lock_pkg::OP_LOCK_SET);
            state_next.read_block  = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        state_reg <= state_next;
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign HREADYOUT          = 1'b1;
    assign HRESP              = 1'b0;
    assign HRDATA             = state_reg.rdata;
    assign LPM_DATA           = state_reg.lpm_data;
    assign LPM_VALID          = state_reg.lpm_valid;
    assign FLASH_ERASE_GO     = state_reg.erase_go;
    assign PAGE_WRITE_CMD     = state_reg.pgwr_go;
    assign FLASH_PROG_BUSY    = state_reg.prog_busy;
    assign SECTION_READ_BLOCK = state_reg.read_block;
    assign LOCK_PROG_MASK     = state_reg.lock_mask;
    assign LOCK_PROG_STROBE   = state_reg.lock_strobe;

endmodule : boot_lock_fuse_access

`default_nettype wire

// ### hw/boot_lock_pkg.sv
// Constants and types shared by the boot lock and fuse access block
package boot_lock_pkg;

    // ********************************************************************
    // Bus map
    // ********************************************************************
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // ********************************************************************
    // Control/status field positions
    // ********************************************************************
    localparam int EN_BIT       = 0;
    localparam int ERASE_BIT    = 1;
    localparam int PGWR_BIT     = 2;
    localparam int SELECT_BIT   = 3;
    localparam int REENABLE_BIT = 4;
    localparam int BUSYFLAG_BIT = 6;
    localparam logic [4:0] CMD_MASK = 5'h1f;

    // ********************************************************************
    // Command codes in the low five control bits
    // ********************************************************************
    localparam logic [4:0] CMD_LOCK_SET  = 5'h09;
    localparam logic [4:0] CMD_ERASE     = 5'h03;
    localparam logic [4:0] CMD_PAGE_WR   = 5'h05;
    localparam logic [4:0] CMD_REENABLE  = 5'h11;

    // ********************************************************************
    // Z-pointer selectors for lock and fuse read-back
    // ********************************************************************
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;

    // ********************************************************************
    // Lock byte layout and reset values
    // ********************************************************************
    localparam int LOCK_BOOT_LSB = 2;
    localparam int LOCK_BOOT_MSB = 5;
    localparam logic [5:0] LOCK_MASK_NONE = 6'h3f;
    localparam logic [1:0] LOCK_UNUSED_HI = 2'h3;

    // ********************************************************************
    // Timed windows and programming time
    // ********************************************************************
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam int CLK_PERIOD_NS    = 20;
    localparam int PROG_MIN_TIME_NS = 3700000;
    localparam int PROG_MAX_TIME_NS = 4500000;
    localparam int PROG_CYCLES      = (PROG_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W       = 18;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [2:0] {
        OP_NONE,
        OP_LOCK_SET,
        OP_ERASE,
        OP_PAGE_WR,
        OP_REENABLE,
        OP_READ_ARMED
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_PROG
    } seq_state_t;

endpackage : boot_lock_pkg

// ### hw/prog_timer.sv
// Flash programming timer that survives a reset once started
`timescale 1ns/1ps
`default_nettype none

module prog_timer #(
    parameter int CYCLES = boot_lock_pkg::PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    typedef struct packed {
        logic                                busy;
        logic                                done;
        logic [boot_lock_pkg::PROG_CNT_W-1:0] cnt;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    // ********************************************************************
    // Countdown
    // ********************************************************************
    always_comb begin
        state_next      = state_reg;
        state_next.done = 1'b0;
        if (state_reg.busy) begin
            if (state_reg.cnt == '0) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt - 1'b1;
            end
        end else if (!rst_b) begin
            state_next = '0;
        end else if (start) begin
            state_next.busy = 1'b1;
            state_next.cnt  = boot_lock_pkg::PROG_CNT_W'(CYCLES - 1);
        end
    end

    // A running write ignores reset so the cells never see a cut pulse
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    assign busy = state_reg.busy;
    assign done = state_reg.done;

endmodule : prog_timer

`default_nettype wire

// ### sim/boot_lock_props.sv
// Checker for the boot lock and fuse access block
`timescale 1ns/1ps
`default_nettype none
module boot_lock_props #(
    parameter int PROG_CYCLES = 20
) (
    input wire logic        CORE_CLK,
    input wire logic        RST_B,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        SPM_EXEC,
    input wire logic        LPM_EXEC,
    input wire logic [15:0] Z_POINTER,
    input wire logic [7:0]  FLASH_READ_BYTE,
    input wire logic        EEPROM_WRITE_BUSY,
    input wire logic [7:0]  LPM_DATA,
    input wire logic        LPM_VALID,
    input wire logic        FLASH_ERASE_GO,
    input wire logic        PAGE_WRITE_CMD,
    input wire logic        FLASH_PROG_BUSY,
    input wire logic        SECTION_READ_BLOCK,
    input wire logic [5:0]  LOCK_PROG_MASK,
    input wire logic        LOCK_PROG_STROBE
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    logic [31:0] busy_cnt;
    // No reset here: the programming timer outlives a reset, so must its length count
    always_ff @(posedge CORE_CLK) begin
        busy_cnt <= FLASH_PROG_BUSY ? busy_cnt + 32'h1 : 32'h0;
    end
    AST_LPM_ANSWER: assert property (LPM_EXEC |=> LPM_VALID)
        else $error("load result not flagged");
    AST_VALID_CAUSE: assert property (LPM_VALID |-> $past(LPM_EXEC))
        else $error("load result without load");
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or error");
    AST_PLAIN_LPM: assert property (LPM_EXEC && Z_POINTER > 16'h3 |=> LPM_DATA == $past(FLASH_READ_BYTE))
        else $error("plain load wrong byte");
    AST_EE_LPM: assert property (LPM_EXEC && EEPROM_WRITE_BUSY |=> LPM_DATA == $past(FLASH_READ_BYTE))
        else $error("read not blocked by eeprom write");
    AST_EE_SPM: assert property (SPM_EXEC && EEPROM_WRITE_BUSY && !FLASH_PROG_BUSY |=> !FLASH_PROG_BUSY [*2])
        else $error("program not blocked by eeprom write");
    AST_LOCK_NO_BLOCK: assert property (LOCK_PROG_STROBE |-> !SECTION_READ_BLOCK && LOCK_PROG_MASK[1:0] == 2'h3)
        else $error("lock write blocked reads or bad mask");
    AST_PROG_TIME: assert property ($fell(FLASH_PROG_BUSY) |-> busy_cnt >= PROG_CYCLES - 1 && busy_cnt <= PROG_CYCLES + 1)
        else $error("programming time wrong");
    AST_STROBE_PULSE: assert property (LOCK_PROG_STROBE |=> !LOCK_PROG_STROBE)
        else $error("commit strobe too long");
    AST_ERASE_BLOCK: assert property (FLASH_ERASE_GO || PAGE_WRITE_CMD |-> ##[0:2] SECTION_READ_BLOCK)
        else $error("section not blocked on erase or write");
    COV_LOCK_READ: cover property (LPM_EXEC && Z_POINTER == 16'h1);
    COV_LOCK_COMMIT: cover property (LOCK_PROG_STROBE);
    COV_ERASE: cover property (FLASH_ERASE_GO);
endmodule : boot_lock_props
bind boot_lock_fuse_access boot_lock_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (
    .CORE_CLK, .RST_B, .HREADYOUT, .HRESP, .SPM_EXEC, .LPM_EXEC, .Z_POINTER, .FLASH_READ_BYTE, .EEPROM_WRITE_BUSY,
    .LPM_DATA, .LPM_VALID, .FLASH_ERASE_GO, .PAGE_WRITE_CMD, .FLASH_PROG_BUSY, .SECTION_READ_BLOCK, .LOCK_PROG_MASK,
    .LOCK_PROG_STROBE);
`default_nettype wire

// ### sim/cpu_core_model.sv
// Behavioural CPU core issuing store-program and load-program instructions
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input  wire logic   clk,
    output logic        spm_exec,
    output logic        lpm_exec,
    output logic [15:0] z_ptr,
    output logic [7:0]  reg_zero
);
    initial begin
        spm_exec = 1'b0;
        lpm_exec = 1'b0;
        z_ptr = 16'h5a5a;
        reg_zero = 8'ha5;
    end
    // Interrupts are off, so the gap after the control write is exact
    task automatic run(input logic is_lpm, input int gap, input logic [15:0] z, input logic [7:0] r0);
        repeat (gap) @(posedge clk);
        spm_exec <= ~is_lpm;
        lpm_exec <= is_lpm;
        z_ptr <= z;
        reg_zero <= r0;
        @(posedge clk);
        spm_exec <= 1'b0;
        lpm_exec <= 1'b0;
        // Operands are not held after the instruction; show their inverse
        z_ptr <= ~z;
        reg_zero <= ~r0;
    endtask : run
endmodule : cpu_core_model
`default_nettype wire

// ### sim/boot_lock_fuse_access_tb_top.sv
// Testbench for the boot lock and fuse access block
`timescale 1ns/1ps
`default_nettype none
module boot_lock_fuse_access_tb_top;
    localparam int PROG = 20;
    localparam logic [7:0] CTRL = boot_lock_pkg::CTRL_OFFSET;
    logic        CORE_CLK = 1'b0, RST_B = 1'b0, HWRITE = 1'b0, EEPROM_WRITE_BUSY = 1'b0;
    logic [1:0]  HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [7:0]  FLASH_READ_BYTE = 8'h0, FUSE_LOW_BYTE = 8'h0, FUSE_HIGH_BYTE = 8'h0, FUSE_EXTENDED_BYTE = 8'h0;
    logic [7:0]  LPM_DATA, GENERAL_REGISTER_ZERO, r0;
    logic [5:0]  LOCK_BITS_NV = 6'h0, LOCK_PROG_MASK, m;
    logic [15:0] Z_POINTER, z;
    logic        HREADYOUT, HRESP, SPM_EXEC, LPM_EXEC, LPM_VALID, FLASH_ERASE_GO, PAGE_WRITE_CMD;
    logic        FLASH_PROG_BUSY, SECTION_READ_BLOCK, LOCK_PROG_STROBE;
    int          fails = 0, checked = 0, n, n_go = 0, n_wr = 0;
    always #10 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        if (FLASH_ERASE_GO === 1'b1) n_go++;
        if (PAGE_WRITE_CMD === 1'b1) n_wr++;
    end
    boot_lock_fuse_access #(.PROG_CYCLES(PROG)) i_dut (
        .CORE_CLK, .RST_B, .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT),
        .HREADYOUT, .HRDATA, .HRESP, .SPM_EXEC, .LPM_EXEC, .Z_POINTER, .GENERAL_REGISTER_ZERO, .FLASH_READ_BYTE,
        .EEPROM_WRITE_BUSY, .LOCK_BITS_NV, .FUSE_LOW_BYTE, .FUSE_HIGH_BYTE, .FUSE_EXTENDED_BYTE, .LPM_DATA,
        .LPM_VALID, .FLASH_ERASE_GO, .PAGE_WRITE_CMD, .FLASH_PROG_BUSY, .SECTION_READ_BLOCK, .LOCK_PROG_MASK,
        .LOCK_PROG_STROBE);
    cpu_core_model i_core (.clk(CORE_CLK), .spm_exec(SPM_EXEC), .lpm_exec(LPM_EXEC), .z_ptr(Z_POINTER),
        .reg_zero(GENERAL_REGISTER_ZERO));
    // ********************
    // Tasks
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("Counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic wait_ready;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (n >= 50) begin
            check(32'h0, 32'h1);
            test_done();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        HADDR <= {24'h0, a};
        HWRITE <= wr;
        HTRANS <= 2'h2;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
    endtask : bus
    task automatic poll_idle;
        for (int i = 0; i < 100; i++) begin
            bus(1'b0, CTRL, 32'h0);
            if (rd[boot_lock_pkg::EN_BIT] === 1'b0) return;
        end
        check(rd, 32'h0);
        test_done();
    endtask : poll_idle
    function automatic logic [7:0] exp_lpm(input logic [15:0] zz, input logic armed);
        if (!armed || zz > 16'h3) return FLASH_READ_BYTE;
        case (zz[1:0])
            2'h0: return FUSE_LOW_BYTE;
            2'h1: return {2'h3, LOCK_BITS_NV};
            2'h2: return FUSE_EXTENDED_BYTE;
            default: return FUSE_HIGH_BYTE;
        endcase
    endfunction : exp_lpm
    task automatic lpm_case(input logic [15:0] zz, input int gap, input logic armed);
        FLASH_READ_BYTE <= 8'($urandom);
        if (armed) bus(1'b1, CTRL, 32'h9);
        i_core.run(1'b1, gap, zz, 8'h0);
        @(negedge CORE_CLK);
        check(LPM_VALID, 32'h1);
        check(LPM_DATA, exp_lpm(zz, armed && gap < 3 && !EEPROM_WRITE_BUSY));
        @(posedge CORE_CLK);
    endtask : lpm_case
    // ********************
    // Main sequence
    // ********************
    initial begin
        void'($urandom(32'h4475));
        repeat (16) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        LOCK_BITS_NV <= 6'($urandom);
        FUSE_LOW_BYTE <= 8'($urandom);
        FUSE_HIGH_BYTE <= 8'($urandom);
        FUSE_EXTENDED_BYTE <= 8'($urandom);
        @(posedge CORE_CLK);
        for (int i = 0; i < 12; i++) begin
            z = i < 4 ? 16'(i) : 16'($urandom % 6);
            lpm_case(z, i < 4 ? 0 : int'($urandom % 4), i < 4 ? 1'b1 : 1'($urandom));
            poll_idle();
            check(rd[boot_lock_pkg::SELECT_BIT], 32'h0);
        end
        $display("Read-back test done");
        for (int g = 0; g <= 4; g++) begin
            r0 = 8'($urandom) | 8'hc3;
            bus(1'b1, CTRL, 32'h9);
            i_core.run(1'b0, g, 16'($urandom), r0);
            repeat (2) @(negedge CORE_CLK);
            if (g < 4) m = {r0[5:2], 2'h3};
            check(FLASH_PROG_BUSY, 32'(g < 4));
            check(LOCK_PROG_MASK, m);
            check(SECTION_READ_BLOCK, 32'h0);
            @(posedge CORE_CLK);
            if (g < 4) begin
                lpm_case(16'h1234, 0, 1'b0);
                if (g == 1) begin
                    RST_B <= 1'b0;
                    repeat (2) @(posedge CORE_CLK);
                    RST_B <= 1'b1;
                end
                n = 0;
                while (LOCK_PROG_STROBE !== 1'b1 && n < PROG + 40) begin
                    @(negedge CORE_CLK);
                    n++;
                end
                check(32'(n < PROG + 40), 32'h1);
                if (n >= PROG + 40) test_done();
                @(posedge CORE_CLK);
            end
            poll_idle();
        end
        $display("Lock write test done");
        EEPROM_WRITE_BUSY <= 1'b1;
        lpm_case(16'h1, 0, 1'b1);
        bus(1'b1, CTRL, 32'h9);
        i_core.run(1'b0, 0, 16'h1, 8'hc3);
        repeat (3) @(posedge CORE_CLK);
        bus(1'b0, boot_lock_pkg::STATUS_OFFSET, 32'h0);
        check(rd[1:0], 32'h2);
        bus(1'b0, CTRL, 32'h0);
        check(rd[4:0], 32'h0);
        EEPROM_WRITE_BUSY <= 1'b0;
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        $display("Interlock test done");
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, CTRL, k == 0 ? 32'h3 : 32'h5);
            i_core.run(1'b0, 0, 16'h0, 8'hff);
            repeat (3) @(negedge CORE_CLK);
            check(SECTION_READ_BLOCK, 32'h1);
            @(posedge CORE_CLK);
            poll_idle();
            check(rd[boot_lock_pkg::BUSYFLAG_BIT], 32'h1);
            bus(1'b1, CTRL, 32'h11);
            i_core.run(1'b0, 1, 16'h0, 8'hff);
            poll_idle();
            check(rd[boot_lock_pkg::BUSYFLAG_BIT], 32'h0);
        end
        check(n_go, 32'h1);
        check(n_wr, 32'h1);
        $display("Erase and write test done");
        test_done();
    end
endmodule : boot_lock_fuse_access_tb_top
`default_nettype wire
